// ---- common/smlc_pkg.sv ----
// package for the serial modem line control block: word layout, reset values, offsets
// assumes a single system clock; the host reaches the word over a plain register port
//
// How it works
// - dtr at value 1, spare pin-11 output at 4, rts at 8.
// - secondary rts output at value 2 of the word.
// - differential driver enable at value 128 of the word.
// - secondary carrier detect input reported at value 256.
// - ring indicator input reported at value 512.
// - carrier detect input reported at value 1024.
// - data set ready input reported at value 2048.
// - clear to send input reported at value 4096.
// - a write loads only the low eight bits into the output latches.
// - a read returns whole word: latches plus live input lines.
// - enable one drives differential outputs; zero leaves them undriven.
// - writes never touch inputs; reads take inputs straight from the lines.
// - rts cleared inhibits transmission on that port.
// - after reset: data at mark, rts and dtr on, secondary rts off.
// - cts off stops transmit at next character boundary; on permits it.

// ****************************************************************
// constants
// ****************************************************************
package smlc_pkg;
  localparam int          WORD_W      = 16;
  localparam int          ADDR_W      = 4;
  localparam int          LATCH_W     = 8;
  // register offsets
  localparam logic [3:0]  OFF_LINE    = 4'h0;
  // bit positions of the word
  localparam int          B_DTR       = 0;
  localparam int          B_SRTS      = 1;
  localparam int          B_SPARE     = 2;
  localparam int          B_RTS       = 3;
  localparam int          B_DEN       = 7;
  localparam int          B_SDCD      = 8;
  localparam int          B_RI        = 9;
  localparam int          B_DCD       = 10;
  localparam int          B_DSR       = 11;
  localparam int          B_CTS       = 12;
  // writable latch bits and reset value: dtr and rts on, others off
  localparam logic [7:0]  LATCH_MASK  = 8'h8F;
  localparam logic [7:0]  LATCH_RST   = 8'h09;
  localparam logic [15:0] ZERO_WORD   = 16'h0000;
endpackage : smlc_pkg

// ---- hw/smlc_sync.sv ----
// two flip-flop synchroniser for a group of pin inputs
// assumes the inputs are asynchronous levels from the line receivers
`timescale 1ns/1ps
`default_nettype none
module smlc_sync #(
  parameter int W = 5
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // lines
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta;

  // first stage read only by the second
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule : smlc_sync
`default_nettype wire

// ---- hw/smlc_tx_gate.sv ----
// transmit permission: rts off stops the uart at once, clear to send off stops it at character boundaries
// assumes the uart pulses char_boundary between characters
`timescale 1ns/1ps
`default_nettype none
module smlc_tx_gate (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // controls
  input  wire logic rts,
  input  wire logic cts,
  input  wire logic char_boundary,
  // result
  output logic      tx_permit
);
  logic next_tx_permit;

  // rts off stops at once; cts off waits for boundary so a character finishes
  assign next_tx_permit = !rts ? 1'b0 :
                          cts ? 1'b1 :
                          char_boundary ? 1'b0 : tx_permit;

  always_ff @(posedge clock) begin
    if (!rst_n) tx_permit <= 1'b0;
    else        tx_permit <= next_tx_permit;
  end
endmodule : smlc_tx_gate
`default_nettype wire

// ---- hw/smlc_line_ctrl.sv ----
// top of the serial modem line control block: control latches, status snapshot
// assumes pins come from another domain; host port is on clock, read data one cycle later
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module smlc_line_ctrl
  import smlc_pkg::*;
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // host register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [WORD_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [WORD_W-1:0] rdata,
  // modem input lines
  input  wire logic              cts_in,
  input  wire logic              dsr_in,
  input  wire logic              dcd_in,
  input  wire logic              ri_in,
  input  wire logic              sdcd_in,
  // modem output lines
  output logic                   dtr_out,
  output logic                   srts_out,
  output logic                   spare_out,
  output logic                   rts_out,
  // uart side
  input  wire logic              uart_txd,
  input  wire logic              char_boundary,
  output logic                   txd_out,
  output logic                   tx_permit,
  // differential transmit pair
  output logic                   diff_tx_p,
  output logic                   diff_tx_n,
  output logic                   diff_tx_oe
);
  // ****************************************************************
  // output latches and input snapshot
  // ****************************************************************
  logic [LATCH_W-1:0] latch;
  logic [4:0]         lines;
  logic [WORD_W-1:0]  status_word;
  logic               sel_line;
  logic               diff_driver_enable;

  smlc_sync #(.W(5)) u_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in ({cts_in, dsr_in, dcd_in, ri_in, sdcd_in}),
    .sync_out (lines)
  );

  // decode
  assign sel_line = (addr == OFF_LINE);

  // word assembly; unassigned bits stay zero
  always_comb begin
    status_word         = ZERO_WORD;
    status_word[B_DTR]  = latch[B_DTR];
    status_word[B_SPARE] = latch[B_SPARE];
    status_word[B_RTS]  = latch[B_RTS];
    status_word[B_SRTS] = latch[B_SRTS];
    status_word[B_DEN]  = latch[B_DEN];
    status_word[B_SDCD] = lines[0];
    status_word[B_RI]   = lines[1];
    status_word[B_DCD]  = lines[2];
    status_word[B_DSR]  = lines[3];
    status_word[B_CTS]  = lines[4];
  end

  // latches take only low byte, masked to assigned bits; inputs never written
  always_ff @(posedge clock) begin
    if (!rst_n)            latch <= LATCH_RST;
    else if (wr && sel_line) latch <= wdata[LATCH_W-1:0] & LATCH_MASK;
  end

  // read data one cycle after strobe, inputs taken live; other addresses read zero
  always_ff @(posedge clock) begin
    if (!rst_n)                rdata <= ZERO_WORD;
    else if (rd && sel_line)   rdata <= status_word;
    else                       rdata <= ZERO_WORD;
  end

  // ****************************************************************
  // line drivers
  // ****************************************************************
  assign dtr_out            = latch[B_DTR];
  assign srts_out           = latch[B_SRTS];
  assign spare_out          = latch[B_SPARE];
  assign rts_out            = latch[B_RTS];
  assign diff_driver_enable = latch[B_DEN];

  smlc_tx_gate u_gate (
    .clock         (clock),
    .rst_n         (rst_n),
    .rts           (latch[B_RTS]),
    .cts           (lines[4]),
    .char_boundary (char_boundary),
    .tx_permit     (tx_permit)
  );

  // idle line held at mark while transmit is not permitted
  always_ff @(posedge clock) begin
    if (!rst_n) txd_out <= 1'b1;
    else        txd_out <= tx_permit ? uart_txd : 1'b1;
  end

  // differential pair driven only while enabled
  assign diff_tx_oe = diff_driver_enable;
  assign diff_tx_p  = txd_out;
  assign diff_tx_n  = ~txd_out;

  // ****************************************************************
  // assertions
  // ****************************************************************
  reset_latch_a: assert property (@(posedge clock) $rose(rst_n) |-> dtr_out && rts_out && !srts_out)
    else $error("reset latch values wrong");
  write_low_a: assert property (@(posedge clock) disable iff (!rst_n)
    wr && sel_line |=> latch == ($past(wdata[7:0]) & LATCH_MASK))
    else $error("write did not load low byte");
  read_cts_a: assert property (@(posedge clock) disable iff (!rst_n)
    rd && sel_line |=> rdata[B_CTS] == $past(lines[4]))
    else $error("cts bit wrong");
  read_dsr_a: assert property (@(posedge clock) disable iff (!rst_n)
    rd && sel_line |=> rdata[B_DSR] == $past(lines[3]) && rdata[B_DCD] == $past(lines[2]))
    else $error("dsr or dcd bit wrong");
  read_ri_a: assert property (@(posedge clock) disable iff (!rst_n)
    rd && sel_line |=> rdata[B_RI] == $past(lines[1]) && rdata[B_SDCD] == $past(lines[0]))
    else $error("ri or sdcd bit wrong");
  read_out_a: assert property (@(posedge clock) disable iff (!rst_n)
    rd && sel_line |=> rdata[3:0] == {$past(rts_out), $past(spare_out), $past(srts_out), $past(dtr_out)})
    else $error("output bits wrong");
  unused_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
    rd |=> rdata[15:13] == 3'h0 && rdata[6:4] == 3'h0)
    else $error("unassigned bits nonzero");
  diff_oe_a: assert property (@(posedge clock) disable iff (!rst_n)
    rd && sel_line |=> rdata[B_DEN] == diff_tx_oe)
    else $error("driver enable mismatch");
  rts_stop_a: assert property (@(posedge clock) disable iff (!rst_n)
    !rts_out |=> !tx_permit)
    else $error("transmit not inhibited");
  cts_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    tx_permit && !lines[4] && !char_boundary && rts_out |=> tx_permit)
    else $error("transmit stopped mid character");

  // ****************************************************************
  // assertion helpers
  // ****************************************************************
  // edges since reset, so the synchroniser check skips its flush
  logic [1:0] settle;

  // saturates at three; only assertions read it
  always_ff @(posedge clock) begin
    if (!rst_n)              settle <= 2'h0;
    else if (settle != 2'h3) settle <= settle + 2'h1;
  end

  // ****************************************************************
  // assertions on the output latches
  // ****************************************************************

  // each output pin is its latch bit, so a write shows one edge later
  dtr_pin_a: assert property (@(posedge clock) disable iff (!rst_n)
    wr && sel_line |=> dtr_out == $past(wdata[B_DTR]))
    else $error("dtr pin did not follow write");

  // spare pin-11 output follows its bit
  spare_pin_a: assert property (@(posedge clock) disable iff (!rst_n)
    wr && sel_line |=> spare_out == $past(wdata[B_SPARE]))
    else $error("spare pin did not follow write");

  // rts follows its bit
  rts_pin_a: assert property (@(posedge clock) disable iff (!rst_n)
    wr && sel_line |=> rts_out == $past(wdata[B_RTS]))
    else $error("rts pin did not follow write");

  // secondary rts follows its bit
  srts_pin_a: assert property (@(posedge clock) disable iff (!rst_n)
    wr && sel_line |=> srts_out == $past(wdata[B_SRTS]))
    else $error("secondary rts pin did not follow write");

  // driver enable follows its bit
  den_pin_a: assert property (@(posedge clock) disable iff (!rst_n)
    wr && sel_line |=> diff_tx_oe == $past(wdata[B_DEN]))
    else $error("driver enable did not follow write");

  // without a write the latches keep their value
  hold_latch_a: assert property (@(posedge clock) disable iff (!rst_n)
    !wr |=> $stable(latch))
    else $error("latch changed without a write");

  // a write elsewhere leaves the latches alone
  unmapped_wr_a: assert property (@(posedge clock) disable iff (!rst_n)
    wr && !sel_line |=> $stable(latch))
    else $error("unmapped write reached the latch");

  // latch bits without a line never become set
  high_bits_a: assert property (@(posedge clock) disable iff (!rst_n)
    latch[6:4] == 3'h0)
    else $error("unassigned latch bit set");

  // ****************************************************************
  // assertions on the read word
  // ****************************************************************

  // secondary rts read back from its latch
  read_srts_a: assert property (@(posedge clock) disable iff (!rst_n)
    rd && sel_line |=> rdata[B_SRTS] == $past(latch[B_SRTS]))
    else $error("secondary rts bit wrong");

  // driver enable read back from its latch
  read_den_a: assert property (@(posedge clock) disable iff (!rst_n)
    rd && sel_line |=> rdata[B_DEN] == $past(latch[B_DEN]))
    else $error("enable bit wrong");

  // dtr read back from its latch
  read_dtr_a: assert property (@(posedge clock) disable iff (!rst_n)
    rd && sel_line |=> rdata[B_DTR] == $past(latch[B_DTR]))
    else $error("dtr bit wrong");

  // rts read back from its latch
  read_rts_a: assert property (@(posedge clock) disable iff (!rst_n)
    rd && sel_line |=> rdata[B_RTS] == $past(latch[B_RTS]))
    else $error("rts bit wrong");

  // spare read back from its latch
  read_spare_a: assert property (@(posedge clock) disable iff (!rst_n)
    rd && sel_line |=> rdata[B_SPARE] == $past(latch[B_SPARE]))
    else $error("spare bit wrong");

  // secondary carrier detect taken from the synchronised line
  read_sdcd_a: assert property (@(posedge clock) disable iff (!rst_n)
    rd && sel_line |=> rdata[B_SDCD] == $past(lines[0]))
    else $error("secondary carrier bit wrong");

  // carrier detect taken from the synchronised line
  read_dcd_a: assert property (@(posedge clock) disable iff (!rst_n)
    rd && sel_line |=> rdata[B_DCD] == $past(lines[2]))
    else $error("carrier bit wrong");

  // read data stand for one cycle only, then fall back to zero
  idle_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
    !(rd && sel_line) |=> rdata == ZERO_WORD)
    else $error("read data outside read cycle");

  // reads elsewhere give zero
  unmapped_rd_a: assert property (@(posedge clock) disable iff (!rst_n)
    rd && !sel_line |=> rdata == ZERO_WORD)
    else $error("unmapped read nonzero");

  // inputs reach the word two edges after the pins, never from a stored copy
  read_live_a: assert property (@(posedge clock) disable iff (!rst_n)
    settle == 2'h3 |-> lines == $past({cts_in, dsr_in, dcd_in, ri_in, sdcd_in}, 2))
    else $error("input lines not live");

  // ****************************************************************
  // assertions on the transmit path
  // ****************************************************************

  // line idles at mark while transmit is not permitted
  txd_mark_a: assert property (@(posedge clock) disable iff (!rst_n)
    !tx_permit |=> txd_out)
    else $error("line not at mark while inhibited");

  // uart data pass while permitted
  txd_follow_a: assert property (@(posedge clock) disable iff (!rst_n)
    tx_permit |=> txd_out == $past(uart_txd))
    else $error("uart data not passed");

  // permission never stands without rts the edge before
  permit_rts_a: assert property (@(posedge clock) disable iff (!rst_n)
    tx_permit |-> $past(rts_out))
    else $error("permit without rts");

  // cts on with rts grants permission next edge
  cts_grant_a: assert property (@(posedge clock) disable iff (!rst_n)
    rts_out && lines[4] |=> tx_permit)
    else $error("transmit not permitted");

  // cts off stops at the boundary
  cts_stop_a: assert property (@(posedge clock) disable iff (!rst_n)
    tx_permit && !lines[4] && char_boundary |=> !tx_permit)
    else $error("transmit not stopped at boundary");

  // permission only rises when cts was on
  permit_rise_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(tx_permit) |-> $past(lines[4]))
    else $error("permit rose without cts");

  // the pair carries the line data while driven
  diff_pair_a: assert property (@(posedge clock) disable iff (!rst_n)
    diff_tx_oe |-> diff_tx_p == txd_out && diff_tx_n != txd_out)
    else $error("pair data wrong");

  // ****************************************************************
  // assertions on reset
  // ****************************************************************

  // reset puts the line at mark and withdraws permission
  reset_txd_a: assert property (@(posedge clock)
    !rst_n |=> txd_out && !tx_permit)
    else $error("reset line state wrong");

  // reset leaves the pair undriven and the secondary lines off
  reset_den_a: assert property (@(posedge clock)
    !rst_n |=> !diff_tx_oe && !spare_out && !srts_out)
    else $error("reset enable state wrong");
  cov_write_c: cover property (@(posedge clock) wr && sel_line);
  cov_read_c: cover property (@(posedge clock) rd && sel_line ##1 rdata[B_CTS]);
  cov_stop_c: cover property (@(posedge clock) tx_permit ##1 !tx_permit);
  cov_den_c: cover property (@(posedge clock) wr && sel_line ##1 diff_tx_oe);
  cov_bound_c: cover property (@(posedge clock) tx_permit && !lines[4] && char_boundary);
endmodule : smlc_line_ctrl
`default_nettype wire

// ---- verif/smlc_modem_model.sv ----
// modem side: drives the five status lines toward the block
// assumes the bench sets wanted levels at a rising edge
`timescale 1ns/1ps
`default_nettype none
module smlc_modem_model (
  // clock
  input  wire logic       clock,
  // wanted levels {cts,dsr,dcd,ri,sdcd}
  input  wire logic [4:0] want,
  // lines
  output logic            cts,
  output logic            dsr,
  output logic            dcd,
  output logic            ri,
  output logic            sdcd
);
  // lines follow one edge late, like a slow modem
  initial {cts, dsr, dcd, ri, sdcd} = 5'h00;
  always @(posedge clock) begin
    {cts, dsr, dcd, ri, sdcd} <= want;
  end
endmodule : smlc_modem_model
`default_nettype wire

// ---- verif/serial_modem_line_control_test.sv ----
// bench for the line control block: random words, status lines, tx gate
// assumes read data stand one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module serial_modem_line_control_test;
  import smlc_pkg::*;
  // ****
  // signals
  // ****
  logic              clock = 1'b0;
  logic              rst_n = 1'b0;
  logic              wr    = 1'b0;
  logic              rd    = 1'b0;
  logic              utx   = 1'b1;
  logic              cb    = 1'b0;
  logic [ADDR_W-1:0] addr  = 4'h0;
  logic [WORD_W-1:0] wdata = 16'h0000;
  logic [WORD_W-1:0] rdata;
  logic [4:0]        want  = 5'h00;
  logic cts, dsr, dcd, ri, sdcd, dtr, srts, spare, rts, txd, permit, dp, dn, doe;
  int n_mismatch = 0, total_checks = 0, seed = 64, lat = 'h09, exp;
  wire [15:0] outs = {8'h00, doe, 3'b000, rts, spare, srts, dtr};
  always #10 clock = ~clock;
  smlc_modem_model u_modem (.clock(clock), .want(want), .cts(cts), .dsr(dsr),
    .dcd(dcd), .ri(ri), .sdcd(sdcd));
  smlc_line_ctrl u_dut (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .cts_in(cts), .dsr_in(dsr), .dcd_in(dcd),
    .ri_in(ri), .sdcd_in(sdcd), .dtr_out(dtr), .srts_out(srts), .spare_out(spare),
    .rts_out(rts), .uart_txd(utx), .char_boundary(cb), .txd_out(txd),
    .tx_permit(permit), .diff_tx_p(dp), .diff_tx_n(dn), .diff_tx_oe(doe));
  // ****
  // tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] e, input string s);
    total_checks++;
    if (got !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h exp %h", $time, s, got, e);
    end
  endtask : chk
  // write also moves the modem lines and uart data at the same edge
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d, input logic [4:0] w);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    want <= w;
    utx <= d[15];
    @(posedge clock);
    wr <= 1'b0;
    if (a == OFF_LINE) lat = d & 16'h008F;
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict
  // ****
  // sequence
  // ****
  initial begin
    logic [15:0] r;
    logic [15:0] d;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    rd_reg(OFF_LINE, r);
    chk(r, 16'h0009, "reset word");
    chk({txd, permit, outs}, 18'h20009, "reset lines");
    $display("test reset done");
    // random words with random line levels; high bits must not stick
    for (int i = 0; i < 24; i++) begin
      d = 16'($random(seed));
      wr_reg(OFF_LINE, d, 5'($random(seed)));
      chk(outs, lat, "latches");
      repeat (3) @(posedge clock);
      rd_reg(OFF_LINE, r);
      exp = lat | (int'(want) << 8);
      chk(r, exp[15:0], "word");
      chk({dp, dn, doe}, {txd, ~txd, lat[7]}, "pair");
    end
    $display("test random words done");
    wr_reg(4'h5, 16'hFFFF, 5'h00);
    chk(outs, lat, "unmapped write");
    rd_reg(4'h5, r);
    chk(r, 16'h0000, "unmapped read");
    $display("test unmapped done");
    // cts on, rts on: permit, then cts off holds until a boundary
    wr_reg(OFF_LINE, 16'h0088, 5'h10);
    repeat (5) @(posedge clock);
    #1 chk({permit, txd}, 16'h0002, "permit on");
    wr_reg(OFF_LINE, 16'h0088, 5'h00);
    repeat (5) @(posedge clock);
    #1 chk(permit, 16'h0001, "hold to boundary");
    @(posedge clock);
    cb <= 1'b1;
    @(posedge clock);
    cb <= 1'b0;
    repeat (2) @(posedge clock);
    #1 chk({permit, txd}, 16'h0001, "stop at boundary");
    wr_reg(OFF_LINE, 16'h0088, 5'h10);
    repeat (5) @(posedge clock);
    wr_reg(OFF_LINE, 16'h0080, 5'h10);
    repeat (2) @(posedge clock);
    #1 chk({permit, txd}, 16'h0001, "rts off");
    $display("test transmit gate done");
    give_verdict();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    give_verdict();
  end
endmodule : serial_modem_line_control_test
`default_nettype wire
